// >>> include/irq_err_pkg.sv
// Package with register map, field positions and carrier types of the irq and error block.
package irq_err_pkg;

	// ************************************************************
	// Register map and field positions
	// ************************************************************
	// Registers sit one per word, so a byte address is four times the register index.
	localparam logic [9:0]  IRQ0_FLAG_IDX        = 10'h006;
	localparam logic [9:0]  IRQ1_FLAG_IDX        = 10'h007;
	localparam logic [9:0]  IRQ_GROUP0_EN_IDX    = 10'h008;
	localparam logic [9:0]  IRQ_GROUP1_EN_IDX    = 10'h009;
	localparam logic [9:0]  ERR_FLAGS_IDX        = 10'h00A;
	localparam logic [9:0]  CMD_STATE_IDX        = 10'h00B;
	localparam logic [9:0]  RX_CONFIG_IDX        = 10'h00C;
	localparam logic [9:0]  COLL_POS_IDX         = 10'h00D;
	localparam logic [11:0] IRQ1_FLAG_OFFS       = {IRQ1_FLAG_IDX, 2'b00};
	localparam logic [11:0] IRQ_GROUP1_EN_OFFS   = {IRQ_GROUP1_EN_IDX, 2'b00};
	localparam logic [11:0] ERR_FLAGS_OFFS       = {ERR_FLAGS_IDX, 2'b00};
	localparam logic [11:0] IRQ_GROUP0_EN_OFFS   = {IRQ_GROUP0_EN_IDX, 2'b00};
	localparam logic [11:0] IRQ0_FLAG_OFFS       = {IRQ0_FLAG_IDX, 2'b00};
	localparam logic [11:0] RX_CONFIG_OFFS       = {RX_CONFIG_IDX, 2'b00};
	localparam logic [11:0] COLL_POS_OFFS        = {COLL_POS_IDX, 2'b00};
	localparam logic [11:0] CMD_STATE_OFFS       = {CMD_STATE_IDX, 2'b00};

	localparam int PIN_DRIVE_BIT   = 7;
	localparam int PIN_EN_BIT      = 6;
	localparam int CARD_DET_BIT    = 5;
	localparam int PIN_INV_BIT     = 7;
	localparam int ERR_NVM_BIT     = 7;
	localparam int ERR_FIFO_WR_BIT = 6;
	localparam int ERR_OVL_BIT     = 5;
	localparam int ERR_SHORT_BIT   = 4;
	localparam int ERR_NODATA_BIT  = 3;
	localparam int ERR_COLL_BIT    = 2;
	localparam int ERR_PROT_BIT    = 1;
	localparam int ERR_INTEG_BIT   = 0;
	localparam int COLL_AS_INTEG_BIT = 3;
	localparam int MULTI_RX_BIT      = 0;
	localparam int EMD_BIT           = 1;
	localparam int IRQ0_ERR_BIT      = 1;
	localparam int IRQ0_RX_BIT       = 2;

	localparam logic [7:0] EN_RESET    = 8'h00;
	localparam logic [7:0] FLAG_RESET  = 8'h00;
	localparam logic [2:0] MIN_BITS    = 3'h4;
	localparam logic [1:0] MIN_EMD_BYTES = 2'h3;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic       nvm_cmd_error;
		logic       fifo_write;
		logic       fifo_full;
		logic       crc_tx_window;
		logic       in_rx_phase;
		logic       auth_active;
		logic       cl_cmd_start;
		logic       multi_err_written;
		logic       rx_cmd_start;
		logic       transceive_wait_data;
		logic       tx_required;
		logic       fifo_empty;
		logic       frame_end;
		logic [2:0] frame_bits;
		logic [1:0] frame_bytes;
		logic       collision;
		logic       collision_in_eof;
		logic [6:0] collision_pos;
		logic       bad_stop_sof_count;
		logic       parity_crc_error;
		logic       byte_store_req;
	} rx_events_s;

	typedef struct packed {
		logic fifo_write_accept;
		logic byte_store_ok;
		logic receive_decoder_enable;
		logic receive_done_irq;
	} rx_actions_s;

	typedef struct packed {
		logic [7:0] irq0_en;
		logic [7:0] irq1_en;
		logic [7:0] irq0_flags;
		logic [7:0] irq1_flags;
		logic [7:0] err_flags;
		logic [7:0] rx_cfg;
		logic [7:0] coll_pos;
		logic       ovl_lock;
		logic [31:0] prdata;
	} state_s;

endpackage : irq_err_pkg

// >>> rtl/irq_err_ctrl.sv
// Interrupt enable, error flag and interrupt pin logic with an APB register slave.
`timescale 1ns/1ps
// Summary of operation
// - Pin drive bit 7 high selects push-pull, low selects open drain.
// - Global request reaches the pin only while pin enable bit 6 is high.
// - Card detect flag feeds the global request only when bit 5 is high.
// - Each timer flag feeds the global request only when its enable bit is high.
// - Group one enable register at 09h, all eight bits read and write.
// - Set nvm error flag when the last nvm command failed.
// - Set fifo write error on writes during crc, receive phases or authentication.
// - Clear fifo write error on new command, or after flags written in multi mode.
// - Write to full fifo sets overflow; later writes are discarded.
// - Set short frame error when fewer than four bits follow a start of frame.
// - Short frames are dropped silently, decoder stays on, no receive interrupt.
// - Set no-data error when transmission is needed but fifo is empty.
// - Collision sets collision flag and records the first collision position.
// - Collision inside the end of frame symbol does not set the flag.
// - Wrong stop bit, start or byte count sets protocol error and stops reception.
// - On protocol error the last received byte is not stored.
// - Parity or crc mismatch sets integrity error and reception continues.
// - With collision-as-integrity set, a collision also sets integrity error.
// - Receive start, or transceive wait-for-data, clears four receive error flags.
// - Fifo write, overflow, protocol, no-data or integrity error sets error summary.
// - Any enabled flag becoming active sets the summary interrupt flag.
// - Pin inversion bit high inverts the interrupt pin polarity.
module irq_err_ctrl (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [3:0]               pstrb,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire irq_err_pkg::rx_events_s  ev,
	input  wire logic [6:0]               irq0_sources,
	input  wire logic [5:0]               irq1_sources,
	output irq_err_pkg::rx_actions_s      act,
	output logic                          irq_pin_out,
	output logic                          irq_pin_oe
);

	// ************************************************************
	// State and bus decode
	// ************************************************************
	irq_err_pkg::state_s st_reg;
	irq_err_pkg::state_s st_next;

	logic       wr_acc;
	logic       rd_acc;
	logic       hit;
	logic       global_req;
	logic [7:0] err_set;
	logic       coll_counts;
	logic       short_frame;
	logic [7:0] wbyte;

	default clocking chk_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	function automatic logic any_enabled(input logic [7:0] f, input logic [7:0] e,
		input logic [7:0] m);
		any_enabled = |(f & e & m);
	endfunction : any_enabled

	assign wr_acc = psel & penable & pwrite;
	// Read data is captured in the setup cycle, so it stands at the access edge with no wait state.
	assign rd_acc = psel & ~penable & ~pwrite;
	assign hit    = (paddr == irq_err_pkg::IRQ_GROUP1_EN_OFFS) ||
		(paddr == irq_err_pkg::IRQ_GROUP0_EN_OFFS) ||
		(paddr == irq_err_pkg::ERR_FLAGS_OFFS) ||
		(paddr == irq_err_pkg::IRQ0_FLAG_OFFS) ||
		(paddr == irq_err_pkg::IRQ1_FLAG_OFFS) ||
		(paddr == irq_err_pkg::RX_CONFIG_OFFS) ||
		(paddr == irq_err_pkg::COLL_POS_OFFS);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata  = st_reg.prdata;
	assign wbyte   = pstrb[0] ? pwdata[7:0] : 8'h00;

	// ************************************************************
	// Interrupt combination and pin
	// ************************************************************
	// Flag bit 6 of group one is the summary itself, so it is masked out of its own term.
	assign global_req = any_enabled(st_reg.irq0_flags, st_reg.irq0_en, 8'h7F) |
		any_enabled(st_reg.irq1_flags, st_reg.irq1_en, 8'h3F);

	// Open drain only drives the low level; the high level is left to the pull-up.
	always_comb begin
		logic level;
		level = st_reg.irq1_flags[6] & st_reg.irq1_en[irq_err_pkg::PIN_EN_BIT];
		level = level ^ st_reg.irq0_en[irq_err_pkg::PIN_INV_BIT];
		irq_pin_out = level;
		if (st_reg.irq1_en[irq_err_pkg::PIN_DRIVE_BIT]) begin
			irq_pin_oe = 1'b1;
		end else begin
			irq_pin_oe = ~level;
		end
	end

	// ************************************************************
	// Receive side actions
	// ************************************************************
	assign short_frame = ev.frame_end & ((ev.frame_bits < irq_err_pkg::MIN_BITS) |
		(st_reg.rx_cfg[irq_err_pkg::EMD_BIT] & (ev.frame_bytes < irq_err_pkg::MIN_EMD_BYTES)));
	assign coll_counts = ev.collision & ~ev.collision_in_eof;

	always_comb begin
		act.fifo_write_accept      = ev.fifo_write & ~ev.fifo_full & ~st_reg.ovl_lock;
		act.byte_store_ok          = ev.byte_store_req & ~ev.bad_stop_sof_count;
		act.receive_decoder_enable = ~ev.bad_stop_sof_count;
		act.receive_done_irq       = ev.frame_end & ~short_frame & ~ev.bad_stop_sof_count;
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		err_set = 8'h00;
		err_set[irq_err_pkg::ERR_NVM_BIT]     = ev.nvm_cmd_error;
		err_set[irq_err_pkg::ERR_FIFO_WR_BIT] = ev.fifo_write & (ev.crc_tx_window |
			ev.in_rx_phase | ev.auth_active);
		err_set[irq_err_pkg::ERR_OVL_BIT]     = ev.fifo_write & ev.fifo_full;
		err_set[irq_err_pkg::ERR_SHORT_BIT]   = short_frame;
		err_set[irq_err_pkg::ERR_NODATA_BIT]  = ev.tx_required & ev.fifo_empty;
		err_set[irq_err_pkg::ERR_COLL_BIT]    = coll_counts;
		err_set[irq_err_pkg::ERR_PROT_BIT]    = ev.bad_stop_sof_count;
		err_set[irq_err_pkg::ERR_INTEG_BIT]   = ev.parity_crc_error |
			(coll_counts & st_reg.rx_cfg[irq_err_pkg::COLL_AS_INTEG_BIT]);

		// Clears act first so that an error flag set in the same cycle wins.
		if (ev.cl_cmd_start | (st_reg.rx_cfg[irq_err_pkg::MULTI_RX_BIT] &
			ev.multi_err_written)) begin
			st_next.err_flags[irq_err_pkg::ERR_FIFO_WR_BIT] = 1'b0;
		end
		if (ev.cl_cmd_start) begin
			st_next.err_flags[irq_err_pkg::ERR_OVL_BIT] = 1'b0;
			st_next.err_flags[irq_err_pkg::ERR_NODATA_BIT] = 1'b0;
			st_next.ovl_lock = 1'b0;
		end
		if (ev.rx_cmd_start | ev.transceive_wait_data) begin
			st_next.err_flags[irq_err_pkg::ERR_SHORT_BIT] = 1'b0;
			st_next.err_flags[irq_err_pkg::ERR_COLL_BIT]  = 1'b0;
			st_next.err_flags[irq_err_pkg::ERR_PROT_BIT]  = 1'b0;
			st_next.err_flags[irq_err_pkg::ERR_INTEG_BIT] = 1'b0;
			st_next.coll_pos = 8'h00;
		end
		st_next.err_flags = st_next.err_flags | err_set;
		if (err_set[irq_err_pkg::ERR_OVL_BIT]) begin
			st_next.ovl_lock = 1'b1;
		end
		if (coll_counts & ~st_reg.coll_pos[7]) begin
			st_next.coll_pos = {1'b1, ev.collision_pos};
		end

		// Register writes; flag registers use bit 7 to choose set or clear.
		if (wr_acc & pstrb[0]) begin
			case (paddr)
				irq_err_pkg::IRQ_GROUP1_EN_OFFS: st_next.irq1_en = wbyte;
				irq_err_pkg::IRQ_GROUP0_EN_OFFS: st_next.irq0_en = wbyte;
				irq_err_pkg::RX_CONFIG_OFFS:     st_next.rx_cfg = wbyte;
				irq_err_pkg::IRQ0_FLAG_OFFS: begin
					st_next.irq0_flags[6:0] = wbyte[7] ? (st_reg.irq0_flags[6:0] | wbyte[6:0]) :
						(st_reg.irq0_flags[6:0] & ~wbyte[6:0]);
				end
				irq_err_pkg::IRQ1_FLAG_OFFS: begin
					st_next.irq1_flags[5:0] = wbyte[7] ? (st_reg.irq1_flags[5:0] | wbyte[5:0]) :
						(st_reg.irq1_flags[5:0] & ~wbyte[5:0]);
				end
				default: st_next.rx_cfg = st_next.rx_cfg;
			endcase
		end
		// Hardware sources set after the software clear, so events are never lost.
		st_next.irq0_flags[6:0] = st_next.irq0_flags[6:0] | irq0_sources;
		st_next.irq0_flags[irq_err_pkg::IRQ0_RX_BIT] = st_next.irq0_flags[irq_err_pkg::IRQ0_RX_BIT] |
			act.receive_done_irq;
		st_next.irq0_flags[irq_err_pkg::IRQ0_ERR_BIT] = st_next.irq0_flags[irq_err_pkg::IRQ0_ERR_BIT] |
			(|(err_set & 8'h6B));
		st_next.irq1_flags[5:0] = st_next.irq1_flags[5:0] | irq1_sources;
		// The summary follows the enabled flags one cycle later and drops when they are gone.
		st_next.irq1_flags[6] = global_req;
		st_next.irq1_flags[7] = 1'b0;
		st_next.irq0_flags[7] = 1'b0;

		st_next.prdata = 32'h0000_0000;
		if (rd_acc) begin
			case (paddr)
				irq_err_pkg::IRQ_GROUP1_EN_OFFS: st_next.prdata = {24'h000000, st_reg.irq1_en};
				irq_err_pkg::IRQ_GROUP0_EN_OFFS: st_next.prdata = {24'h000000, st_reg.irq0_en};
				irq_err_pkg::ERR_FLAGS_OFFS:     st_next.prdata = {24'h000000, st_reg.err_flags};
				irq_err_pkg::IRQ0_FLAG_OFFS:     st_next.prdata = {24'h000000, st_reg.irq0_flags};
				irq_err_pkg::IRQ1_FLAG_OFFS:     st_next.prdata = {24'h000000, st_reg.irq1_flags};
				irq_err_pkg::RX_CONFIG_OFFS:     st_next.prdata = {24'h000000, st_reg.rx_cfg};
				irq_err_pkg::COLL_POS_OFFS:      st_next.prdata = {24'h000000, st_reg.coll_pos};
				default:                         st_next.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_pin_gated: assert property (@(posedge pclk) disable iff (!presetn)
		!st_reg.irq1_en[6] |-> irq_pin_out == st_reg.irq0_en[7])
		else $error("Interrupt pin active while pin output disabled.");
	a_push_pull_oe: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg.irq1_en[7] |-> irq_pin_oe) else $error("Push-pull pin not driven.");
	a_open_drain_high: assert property (@(posedge pclk) disable iff (!presetn)
		(!st_reg.irq1_en[7] && irq_pin_out) |-> !irq_pin_oe)
		else $error("Open-drain pin drove a high level.");
	a_en_write_read: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && pstrb[0] && paddr == irq_err_pkg::IRQ_GROUP1_EN_OFFS) |=> st_reg.irq1_en
		== $past(pwdata[7:0])) else $error("Enable register did not take written value.");
	a_timer_mask: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.irq1_en[5:0] == 6'h00 && st_reg.irq0_en[6:0] == 7'h00) |=> !st_reg.irq1_flags[6])
		else $error("Summary set with all sources disabled.");
	a_card_det_irq: assert property (@(posedge pclk) disable iff (!presetn)
		(st_reg.irq1_flags[5] && st_reg.irq1_en[5]) |=> st_reg.irq1_flags[6])
		else $error("Enabled card detect did not raise summary.");
	a_ovl_discard: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg.ovl_lock |-> !act.fifo_write_accept) else $error("Write accepted after overflow.");
	a_prot_store: assert property (@(posedge pclk) disable iff (!presetn)
		ev.bad_stop_sof_count |-> !act.byte_store_ok ##1 st_reg.err_flags[1])
		else $error("Byte stored on protocol error.");
	a_coll_eof: assert property (@(posedge pclk) disable iff (!presetn)
		(ev.collision && ev.collision_in_eof && !st_reg.err_flags[2] && !ev.rx_cmd_start)
		|=> !st_reg.err_flags[2]) else $error("Collision in end of frame set the flag.");
	a_integ_coll: assert property (@(posedge pclk) disable iff (!presetn)
		(coll_counts && st_reg.rx_cfg[3]) |=> st_reg.err_flags[0])
		else $error("Collision did not set integrity error.");
	a_rx_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(ev.rx_cmd_start && err_set[4:0] == 5'h00) |=> st_reg.err_flags[4] == 1'b0 &&
		st_reg.err_flags[1:0] == 2'h0) else $error("Receive start did not clear flags.");
	a_err_summary: assert property (@(posedge pclk) disable iff (!presetn)
		ev.tx_required && ev.fifo_empty |=> st_reg.irq0_flags[1] && st_reg.err_flags[3])
		else $error("No-data error did not raise error summary.");

	// ************************************************************
	// Rule checks
	// ************************************************************

	a_nvm_err_set: assert property (
		ev.nvm_cmd_error
		|=> st_reg.err_flags[7])
		else $error("Nvm error flag not set.");

	a_wr_err_set: assert property (
		ev.fifo_write && (ev.crc_tx_window || ev.in_rx_phase || ev.auth_active)
		|=> st_reg.err_flags[6])
		else $error("Fifo write error not set.");

	a_wr_err_clear: assert property (
		ev.cl_cmd_start && !err_set[6]
		|=> !st_reg.err_flags[6])
		else $error("Fifo write error not cleared on command.");

	a_multi_rx_clear: assert property (
		st_reg.rx_cfg[0] && ev.multi_err_written && !err_set[6]
		|=> !st_reg.err_flags[6])
		else $error("Fifo write error not cleared in multi mode.");

	a_ovl_set: assert property (
		ev.fifo_write && ev.fifo_full
		|=> st_reg.err_flags[5] && st_reg.ovl_lock)
		else $error("Overflow flag not set.");

	a_full_discard: assert property (
		ev.fifo_full
		|-> !act.fifo_write_accept)
		else $error("Write accepted into full fifo.");

	a_short_set: assert property (
		ev.frame_end && ev.frame_bits < irq_err_pkg::MIN_BITS
		|=> st_reg.err_flags[4])
		else $error("Short frame error not set.");

	a_short_drop: assert property (
		short_frame && !ev.bad_stop_sof_count
		|-> act.receive_decoder_enable && !act.receive_done_irq)
		else $error("Short frame not dropped silently.");

	a_emd_short: assert property (
		ev.frame_end && st_reg.rx_cfg[1] && ev.frame_bytes < irq_err_pkg::MIN_EMD_BYTES
		|-> !act.receive_done_irq)
		else $error("Short frame raised receive interrupt.");

	a_nodata_quiet: assert property (
		!(ev.tx_required && ev.fifo_empty) && !st_reg.err_flags[3]
		|=> !st_reg.err_flags[3])
		else $error("No-data error set without cause.");

	a_coll_set: assert property (
		coll_counts
		|=> st_reg.err_flags[2])
		else $error("Collision flag not set.");

	a_coll_pos_first: assert property (
		coll_counts && !st_reg.coll_pos[7]
		|=> st_reg.coll_pos == {1'b1, $past(ev.collision_pos)})
		else $error("Collision position not recorded.");

	a_coll_pos_hold: assert property (
		st_reg.coll_pos[7] && !ev.rx_cmd_start && !ev.transceive_wait_data
		|=> $stable(st_reg.coll_pos))
		else $error("First collision position overwritten.");

	a_prot_stop: assert property (
		ev.bad_stop_sof_count
		|-> !act.receive_decoder_enable)
		else $error("Reception not stopped on protocol error.");

	a_integ_set: assert property (
		ev.parity_crc_error
		|=> st_reg.err_flags[0])
		else $error("Integrity error not set.");

	a_integ_go_on: assert property (
		ev.parity_crc_error && !ev.bad_stop_sof_count
		|-> act.receive_decoder_enable)
		else $error("Reception stopped on integrity error.");

	a_coll_integ_off: assert property (
		!st_reg.rx_cfg[3] && !ev.parity_crc_error && !st_reg.err_flags[0]
		|=> !st_reg.err_flags[0])
		else $error("Integrity error set without cause.");

	a_txwait_clear: assert property (
		ev.transceive_wait_data && (err_set[4:0] & 5'h17) == 5'h00
		|=> (st_reg.err_flags[4:0] & 5'h17) == 5'h00)
		else $error("Wait for data did not clear flags.");

	a_err_sum_set: assert property (
		(err_set & 8'h6B) != 8'h00
		|=> st_reg.irq0_flags[1])
		else $error("Error summary not set.");

	a_err_sum_quiet: assert property (
		!st_reg.irq0_flags[1] && (err_set & 8'h6B) == 8'h00 && !irq0_sources[1] && !wr_acc
		|=> !st_reg.irq0_flags[1])
		else $error("Error summary set without cause.");

	a_global_set: assert property (
		global_req
		|=> st_reg.irq1_flags[6])
		else $error("Summary flag not set for enabled flag.");

	a_global_quiet: assert property (
		!global_req
		|=> !st_reg.irq1_flags[6])
		else $error("Summary flag set without enabled flag.");

	a_pin_polarity: assert property (
		st_reg.irq1_en[6]
		|-> irq_pin_out == (st_reg.irq1_flags[6] ^ st_reg.irq0_en[7]))
		else $error("Interrupt pin polarity wrong.");

	a_timer_feed: assert property (
		(st_reg.irq1_flags[4:0] & st_reg.irq1_en[4:0]) != 5'h00
		|=> st_reg.irq1_flags[6])
		else $error("Enabled timer flag did not raise summary.");

	a_rd_data: assert property (
		psel && !penable && !pwrite && paddr == irq_err_pkg::IRQ_GROUP1_EN_OFFS
		|=> prdata == {24'h000000, $past(st_reg.irq1_en)})
		else $error("Enable register read data wrong.");

	a_unmapped_zero: assert property (
		psel && penable && !hit
		|-> prdata == 32'h0000_0000)
		else $error("Unmapped read returned data.");

endmodule : irq_err_ctrl

// >>> verification/irq_host_model.sv
// Host side model that resolves the shared interrupt wire.
`timescale 1ns/1ps
module irq_host_model (
	input  wire logic irq_pin_out,
	input  wire logic irq_pin_oe,
	output logic      irq_wire
);
	// ************************************************************
	// Wire resolution
	// ************************************************************
	// A board pull-up holds the wire high whenever the pin is released.
	assign irq_wire = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule : irq_host_model

// >>> verification/test_irq_enable_and_rx_error_flags.sv
// Self-checking bench for the interrupt enable and receive error flag block.
`timescale 1ns/1ps
`define CHECK_EQ(nm, ex, got) \
	begin \
		total_checks++; \
		if ((got) !== (ex)) begin \
			err_total++; \
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
		end \
	end
module test_irq_enable_and_rx_error_flags;
	// ************************************************************
	// Signals and design hookup
	// ************************************************************
	logic                     pclk = 1'b0;
	logic                     presetn = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [11:0]              paddr = 12'h000;
	logic [31:0]              pwdata = 32'h00000000;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	irq_err_pkg::rx_events_s  ev = '0;
	irq_err_pkg::rx_events_s  e = '0;
	logic [6:0]               irq0_src = 7'h00;
	logic [5:0]               irq1_src = 6'h00;
	irq_err_pkg::rx_actions_s act;
	logic                     pin_out;
	logic                     pin_oe;
	logic                     irq_wire;
	int                       err_total = 0;
	int                       total_checks = 0;
	logic [32:0]              exp_q[$];
	logic [32:0]              note;
	logic [6:0]               cp;
	logic [7:0]               r;
	always #12.5 pclk = ~pclk;
	irq_err_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ev(ev), .irq0_sources(irq0_src),
		.irq1_sources(irq1_src), .act(act), .irq_pin_out(pin_out), .irq_pin_oe(pin_oe));
	irq_host_model host_u (.irq_pin_out(pin_out), .irq_pin_oe(pin_oe), .irq_wire(irq_wire));
	// ************************************************************
	// Read monitor and tasks
	// ************************************************************
	// Read data and the error response are taken at the access edge, where pready is high.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			note = exp_q.pop_front();
			`CHECK_EQ("prdata", note[31:0], prdata)
			`CHECK_EQ("pslverr", note[32], pslverr)
		end
	end
	task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic er = 1'b0);
		exp_q.push_back({er, 24'h000000, x});
		apb(1'b0, a, 8'h00);
	endtask : rd
	task automatic pulse(input logic [3:0] m, input logic [3:0] ax);
		ev <= e;
		@(negedge pclk);
		`CHECK_EQ("act", ax, act & m)
		@(posedge pclk);
		ev <= '0;
		e = '0;
		@(posedge pclk);
	endtask : pulse
	task automatic pin(input logic lvl, input logic oe);
		@(negedge pclk);
		`CHECK_EQ("irq_wire", lvl, irq_wire)
		`CHECK_EQ("irq_pin_oe", oe, pin_oe)
		@(posedge pclk);
	endtask : pin
	task automatic clr();
		e.cl_cmd_start = 1'b1;
		e.rx_cmd_start = 1'b1;
		pulse(4'h0, 4'h0);
		apb(1'b1, irq_err_pkg::IRQ0_FLAG_OFFS, 8'h7F);
		rd(irq_err_pkg::ERR_FLAGS_OFFS, 8'h00);
	endtask : clr
	task automatic step(input logic [7:0] x, input logic [3:0] m, input logic [3:0] ax,
		input logic c);
		pulse(m, ax);
		if (x !== 8'hFF) rd(irq_err_pkg::ERR_FLAGS_OFFS, x);
		if (x !== 8'hFF && (x & 8'h6B) != 8'h00) rd(irq_err_pkg::IRQ0_FLAG_OFFS, 8'h02);
		if (c) clr();
	endtask : step
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		#200000;
		err_total++;
		$display("watchdog expired");
		results();
	end
	initial begin
		void'($urandom(32'h12DBFFDD));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(irq_err_pkg::IRQ_GROUP1_EN_OFFS, 8'h00);
		rd(irq_err_pkg::ERR_FLAGS_OFFS, 8'h00);
		pin(1'b0, 1'b1);
		rd(12'h03C, 8'h00, 1'b1);
		repeat (4) begin
			r = 8'($urandom());
			apb(1'b1, irq_err_pkg::IRQ_GROUP1_EN_OFFS, r);
			rd(irq_err_pkg::IRQ_GROUP1_EN_OFFS, r);
		end
		$display("test registers done");
		for (int b = 0; b < 6; b++) begin
			apb(1'b1, irq_err_pkg::IRQ_GROUP1_EN_OFFS, 8'h40 | (8'h01 << b));
			irq1_src <= 6'h01 << b;
			@(posedge pclk);
			irq1_src <= 6'h00;
			@(posedge pclk);
			rd(irq_err_pkg::IRQ1_FLAG_OFFS, 8'h40 | (8'h01 << b));
			pin(1'b1, 1'b0);
			apb(1'b1, irq_err_pkg::IRQ_GROUP1_EN_OFFS, 8'h80 | (8'h01 << b));
			pin(1'b0, 1'b1);
			apb(1'b1, irq_err_pkg::IRQ_GROUP1_EN_OFFS, 8'hC0);
			rd(irq_err_pkg::IRQ1_FLAG_OFFS, 8'h01 << b);
			pin(1'b0, 1'b1);
			apb(1'b1, irq_err_pkg::IRQ1_FLAG_OFFS, 8'h3F);
		end
		apb(1'b1, irq_err_pkg::IRQ_GROUP0_EN_OFFS, 8'h01);
		irq0_src <= 7'h01;
		@(posedge pclk);
		irq0_src <= 7'h00;
		@(posedge pclk);
		rd(irq_err_pkg::IRQ1_FLAG_OFFS, 8'h40);
		pin(1'b1, 1'b1);
		apb(1'b1, irq_err_pkg::IRQ_GROUP0_EN_OFFS, 8'h81);
		pin(1'b0, 1'b1);
		apb(1'b1, irq_err_pkg::IRQ0_FLAG_OFFS, 8'h7F);
		$display("test enables done");
		e.fifo_write = 1'b1;
		e.crc_tx_window = 1'b1;
		step(8'h40, 4'h0, 4'h0, 1'b1);
		e.fifo_write = 1'b1;
		e.in_rx_phase = 1'b1;
		step(8'h40, 4'h0, 4'h0, 1'b1);
		e.fifo_write = 1'b1;
		e.auth_active = 1'b1;
		step(8'h40, 4'h0, 4'h0, 1'b1);
		e.fifo_write = 1'b1;
		e.fifo_full = 1'b1;
		step(8'h20, 4'h8, 4'h0, 1'b0);
		e.fifo_write = 1'b1;
		step(8'h20, 4'h8, 4'h0, 1'b1);
		e.fifo_write = 1'b1;
		step(8'h00, 4'h8, 4'h8, 1'b0);
		e.frame_end = 1'b1;
		e.frame_bits = 3'h3;
		step(8'h10, 4'h3, 4'h2, 1'b1);
		e.frame_end = 1'b1;
		e.frame_bits = 3'h4;
		step(8'h00, 4'h3, 4'h3, 1'b1);
		e.tx_required = 1'b1;
		e.fifo_empty = 1'b1;
		step(8'h08, 4'h0, 4'h0, 1'b1);
		cp = 7'($urandom());
		e.collision = 1'b1;
		e.collision_pos = cp;
		step(8'h04, 4'h0, 4'h0, 1'b0);
		rd(irq_err_pkg::COLL_POS_OFFS, {1'b1, cp});
		clr();
		e.collision = 1'b1;
		e.collision_in_eof = 1'b1;
		step(8'h00, 4'h0, 4'h0, 1'b0);
		e.bad_stop_sof_count = 1'b1;
		e.byte_store_req = 1'b1;
		step(8'h02, 4'h4, 4'h0, 1'b1);
		e.parity_crc_error = 1'b1;
		step(8'h01, 4'h0, 4'h0, 1'b0);
		e.transceive_wait_data = 1'b1;
		step(8'h00, 4'h0, 4'h0, 1'b1);
		apb(1'b1, irq_err_pkg::RX_CONFIG_OFFS, 8'h08);
		e.collision = 1'b1;
		step(8'h05, 4'h0, 4'h0, 1'b1);
		apb(1'b1, irq_err_pkg::RX_CONFIG_OFFS, 8'h01);
		e.fifo_write = 1'b1;
		e.in_rx_phase = 1'b1;
		step(8'h40, 4'h0, 4'h0, 1'b0);
		e.multi_err_written = 1'b1;
		step(8'h00, 4'h0, 4'h0, 1'b1);
		apb(1'b1, irq_err_pkg::RX_CONFIG_OFFS, 8'h02);
		e.frame_end = 1'b1;
		e.frame_bytes = 2'h2;
		e.frame_bits = 3'h4;
		step(8'h10, 4'h3, 4'h2, 1'b1);
		e.nvm_cmd_error = 1'b1;
		step(8'h80, 4'h0, 4'h0, 1'b0);
		$display("test error flags done");
		results();
	end
endmodule : test_irq_enable_and_rx_error_flags
